// ===== common/sab_defines.vh
// constants for the charge alert and battery detect block
`ifndef SAB_DEFINES_VH
`define SAB_DEFINES_VH
`define SAB_CLK_HZ        10000000
`define SAB_PULSE_US      1000
`define SAB_PULSE_CYCLES  ((`SAB_CLK_HZ / 1000000) * `SAB_PULSE_US)
`define SAB_PCT_FULL      7'h64
`define SAB_PCT_EMPTY     7'h00
`define SAB_STEP_DEFAULT  7'h01
`define SAB_MODE_INIT     2'h0
`define SAB_MODE_PREP     2'h1
`define SAB_MODE_NORMAL   2'h2
`define SAB_INIT_CYCLES   16
`define SAB_CMD_CYCLES    4
`endif

// ===== dv/sab_alert_detect_assertions.sv
// checker for the alert and detect block
`timescale 1ns/1ps
`include "sab_defines.vh"
module sab_chk #(
  parameter PULSE_CYCLES = `SAB_PULSE_CYCLES
) (
  input wire       ref_clk,
  input wire       srst,
  input wire       output_polarity_select,
  input wire       low_battery_output_select,
  input wire [6:0] charge_percent,
  input wire [6:0] first_set_threshold,
  input wire [6:0] final_set_threshold,
  input wire [6:0] final_clear_threshold,
  input wire       general_output_pin,
  input wire       charge_initial_flag,
  input wire       charge_final_flag,
  input wire       battery_inserted,
  input wire [1:0] gauge_mode
);
  reg        pol_d;                                             // polarity the pin register saw
  reg        sel_d;                                             // select the pin register saw
  reg        srst_d;                                            // reset the pin register saw
  wire       act = (general_output_pin ^ pol_d) & ~sel_d & ~srst_d; // pulse seen on the pin
  wire       sel = low_battery_output_select;                   // flag routed to pin
  reg [15:0] run;                                               // active stretch length
  // controls one edge old, so a polarity or select change does not fake an edge
  always @(posedge ref_clk)
  begin
    pol_d  <= output_polarity_select;
    sel_d  <= low_battery_output_select;
    srst_d <= srst;
  end
  // count active cycles, clear when idle
  always @(posedge ref_clk)
    if (srst || !act)
      run <= 16'h0000;
    else
      run <= run + 16'h0001;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (srst);
  property p_track; sel && $past(sel) && !$past(srst) && $stable(charge_initial_flag) && $stable(output_polarity_select)
    |-> general_output_pin == (charge_initial_flag ^ output_polarity_select); endproperty
  a_track: assert property (p_track) else $error("pin not following flag");
  property p_fset; charge_percent < first_set_threshold |=> charge_initial_flag; endproperty
  a_fset: assert property (p_fset) else $error("initial flag not set");
  property p_fclr; charge_percent > first_set_threshold |=> !charge_initial_flag; endproperty
  a_fclr: assert property (p_fclr) else $error("initial flag not cleared");
  property p_xset; charge_percent < final_set_threshold |=> charge_final_flag; endproperty
  a_xset: assert property (p_xset) else $error("final flag not set");
  property p_xclr; charge_percent > final_clear_threshold && charge_percent >= final_set_threshold
    |=> !charge_final_flag; endproperty
  a_xclr: assert property (p_xclr) else $error("final flag not cleared");
  property p_mode; gauge_mode == `SAB_MODE_NORMAL && $past(gauge_mode) != `SAB_MODE_NORMAL
    |-> battery_inserted && $past(gauge_mode) == `SAB_MODE_PREP; endproperty
  a_mode: assert property (p_mode) else $error("normal mode without insertion");
  property p_width; !sel && $past(sel) == 1'b0 && !$past(srst) && $fell(act) |-> run == PULSE_CYCLES; endproperty
  a_width: assert property (p_width) else $error("pulse width wrong");
  property p_long; !sel && $past(sel) == 1'b0 && act |-> run < PULSE_CYCLES; endproperty
  a_long: assert property (p_long) else $error("pulse too long");
  c_pulse: cover property (!sel && $fell(act));
  c_norm: cover property (gauge_mode == `SAB_MODE_NORMAL);
  c_low: cover property (sel && charge_initial_flag);
endmodule // sab_chk
bind sab_alert_detect sab_chk #(.PULSE_CYCLES(PULSE_CYCLES)) u_chk (.*);

// ===== dv/sab_host.sv
// host model driving the detect pin and subcommands
`timescale 1ns/1ps
module sab_host (
  input  wire ref_clk,
  input  wire use_pin,
  input  wire ins_req,
  input  wire rem_req,
  output reg  battery_present_input,
  output reg  insert_subcommand,
  output reg  remove_subcommand
);
  // weak pull-up: no pack at start
  initial {battery_present_input, insert_subcommand, remove_subcommand} = 3'h4;
  // one-cycle requests become pin edges or subcommand pulses
  always @(posedge ref_clk)
  begin
    insert_subcommand <= ins_req && !use_pin;
    remove_subcommand <= rem_req && !use_pin;
    if (use_pin && ins_req)
      battery_present_input <= 1'b0;
    if (use_pin && rem_req)
      battery_present_input <= 1'b1;
  end
endmodule // sab_host

// ===== dv/tb.sv
// bench for the alert and detect block
`timescale 1ns/1ps
module tb;
  localparam PW = 20; // shortened pulse
  localparam [41:0] TP = {7'h19, 7'h14, 7'h10, 7'h0C, 7'h05, 7'h0F}; // percent sweep
  localparam [11:0] TE = {2'h0, 2'h2, 2'h2, 2'h3, 2'h3, 2'h2};       // initial, final
  reg        ref_clk, srst, output_polarity_select, low_battery_output_select, pin_detect_enable;
  reg        charging, discharging, host_command, by_pin, ins_req, rem_req;
  reg  [6:0] charge_percent, first_set_threshold, final_set_threshold, final_clear_threshold, charge_step_size;
  wire       battery_present_input, insert_subcommand, remove_subcommand, general_output_pin, core_awake;
  wire       charge_initial_flag, charge_final_flag, battery_inserted, gauging_active;
  wire [1:0] gauge_mode;
  integer    n_errors, tests_run, i, w;
  sab_alert_detect #(.PULSE_CYCLES(PW), .INIT_CYCLES(4), .CMD_CYCLES(4)) DUT (.*);
  sab_host host (.use_pin(by_pin), .*);
  initial
  begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  // wait n edges, then settle
  task step(input integer n);
    repeat (n) @(posedge ref_clk);
    #5;
  endtask
  task chk(input [31:0] nm, input [7:0] e, input [7:0] g);
    tests_run = tests_run + 1;
    if (g !== e)
    begin
      n_errors = n_errors + 1;
      $display("MISMATCH %s exp %0h got %0h", nm, e, g);
    end
  endtask
  task report_and_stop;
    $display("checks %0d errors %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // bounded wait for mode and wake state
  task wst(input [2:0] e);
    for (i = 0; i < 40 && {gauge_mode, core_awake} !== e; i = i + 1)
      step(1);
    chk("mode", e, {gauge_mode, core_awake});
    if (i == 40)
      report_and_stop;
  endtask
  // width of next pulse, 0 if none
  task pw(input [31:0] nm, input [7:0] e);
    w = 0;
    for (i = 0; i < 12 && general_output_pin === output_polarity_select; i = i + 1)
      step(1);
    for (w = 0; w < 60 && general_output_pin !== output_polarity_select; w = w + 1)
      step(1);
    chk(nm, e, w);
    // a pulse that never ends is a hang
    if (w == 60)
      report_and_stop;
  endtask
  // one-cycle host request
  task req(input [1:0] r);
    {ins_req, rem_req} = r;
    step(1);
    {ins_req, rem_req} = 2'h0;
  endtask
  initial
  begin
    n_errors = 0;
    tests_run = 0;
    {srst, output_polarity_select, low_battery_output_select, pin_detect_enable} = 4'hB;
    {charging, discharging, host_command, by_pin, ins_req, rem_req} = 6'h04;
    {first_set_threshold, final_set_threshold, final_clear_threshold} = {7'h14, 7'h0A, 7'h0F};
    charge_percent = 7'h32;
    charge_step_size = 7'h0A;
    step(12);
    srst = 1'b0;
    step(2);
    wst(3'h0);
    req(2'h2);
    wst(3'h5);
    chk("ins", 1, battery_inserted);
    for (i = 0; i < 6; i = i + 1)
    begin
      charge_percent = TP[i*7 +: 7];
      output_polarity_select = i[0];
      step(3);
      chk("ini", TE[i*2+1], charge_initial_flag);
      chk("fin", TE[i*2], charge_final_flag);
      chk("pin", TE[i*2+1] ^ i[0], general_output_pin);
    end
    chk("gau", 1, gauging_active);
    output_polarity_select = 1'b0;
    charge_percent = 7'h33;
    step(3);
    low_battery_output_select = 1'b0;
    step(3);
    discharging = 1'b1;
    pw("dis", PW);
    charge_percent = 7'h32;
    pw("d50", PW);
    charge_percent = 7'h31;
    pw("d49", 0);
    discharging = 1'b0;
    pw("rlx", 0);
    charging = 1'b1;
    pw("chg", PW);
    charge_percent = 7'h3C;
    step(1);
    charge_percent = 7'h46;
    pw("q1", PW);
    pw("q2", PW);
    // removal pulse with the inverted pin polarity
    output_polarity_select = 1'b1;
    step(2);
    req(2'h1);
    pw("rem", PW);
    output_polarity_select = 1'b0;
    step(2);
    wst(3'h0);
    chk("gau", 0, gauging_active);
    host_command = 1'b1;
    step(1);
    host_command = 1'b0;
    wst(3'h1);
    wst(3'h0);
    pin_detect_enable = 1'b0;
    req(2'h2);
    step(8);
    chk("ign", 0, battery_inserted);
    by_pin = 1'b0;
    req(2'h2);
    wst(3'h5);
    req(2'h1);
    pw("srm", 0);
    wst(3'h0);
    // a zero step size silences step and state pulses
    charge_step_size = 7'h00;
    charging = 1'b0;
    discharging = 1'b1;
    charge_percent = 7'h32;
    pw("st0", 0);
    report_and_stop;
  end
endmodule // tb

// ===== src/sab_alert_detect.v
// charge alert output pin and battery presence detection
`timescale 1ns/1ps
`include "sab_defines.vh"
// What this block does
// - polarity select inverts or passes output pin
// - select bit picks low flag or pulses
// - low indicator tracks charge initial flag
// - initial flag set below, cleared above threshold
// - final flag uses separate set/clear thresholds
// - each step, state or pin removal event gives one 1 ms pulse; insertion gives none, queue holds up to 15
// - step crossing pulses while charging or discharging
// - charge/discharge entry pulses, relaxation does not
// - removal pulses when pin detect enabled
// - falling detect pin edge means insertion
// - rising detect pin edge means removal
// - detect pin ignored when pin detect disabled; subcommands used instead
// - insertion plus init done enters normal
// - halted in init, wakes briefly for commands
module sab_alert_detect #(
  parameter PULSE_CYCLES = `SAB_PULSE_CYCLES,
  parameter INIT_CYCLES  = `SAB_INIT_CYCLES,
  parameter CMD_CYCLES   = `SAB_CMD_CYCLES
) (
  input  wire       ref_clk,
  input  wire       srst,
  input  wire       output_polarity_select,
  input  wire       low_battery_output_select,
  input  wire       pin_detect_enable,
  input  wire [6:0] charge_percent,
  input  wire [6:0] first_set_threshold,
  input  wire [6:0] final_set_threshold,
  input  wire [6:0] final_clear_threshold,
  input  wire [6:0] charge_step_size,
  input  wire       charging,
  input  wire       discharging,
  input  wire       battery_present_input,
  input  wire       insert_subcommand,
  input  wire       remove_subcommand,
  input  wire       host_command,
  output reg        general_output_pin,
  output reg        charge_initial_flag,
  output reg        charge_final_flag,
  output reg        battery_inserted,
  output reg  [1:0] gauge_mode,
  output reg        gauging_active,
  output reg        core_awake
);

  // true when pct lies on a step point counted down from full
  function is_step_point;
    input [6:0] pct;
    input [6:0] step;
    reg   [6:0] gap;
    begin
      gap = `SAB_PCT_FULL - pct;
      if (step == 7'h00)
        is_step_point = 1'b0;
      else
        is_step_point = ((gap % step) == 7'h00) || (pct == `SAB_PCT_EMPTY);
    end
  endfunction

  reg        bin_meta;      // first synchroniser stage
  reg        bin_sync;      // second synchroniser stage
  reg        bin_prev;      // previous synchronised value
  reg  [6:0] pct_prev;      // charge percent last cycle
  reg        chg_prev;      // charging last cycle
  reg        dis_prev;      // discharging last cycle
  reg  [3:0] pend_cnt;      // queued pulse events
  reg [31:0] pulse_cnt;     // pulse width counter
  reg        pulse_on;      // pulse in progress
  reg [31:0] init_cnt;      // initialization timer
  reg [31:0] wake_cnt;      // command wake timer
  wire       step_on;       // step events enabled
  wire       ins_evt;       // insertion event
  wire       rem_evt;       // removal event
  wire       step_evt;      // step crossing event
  wire       state_evt;     // charge/discharge entry event
  wire       rem_pulse;     // removal qualifies for a pulse
  wire [2:0] new_evts;      // events this cycle
  wire [4:0] pend_sum;      // queue depth before saturation, one bit wider so it cannot wrap
  wire       start_pulse;   // a pulse begins now
  reg        next_pin;      // next output pin level

  assign step_on   = (charge_step_size != 7'h00);
  assign ins_evt   = pin_detect_enable ? (bin_prev & ~bin_sync) : insert_subcommand;
  assign rem_evt   = pin_detect_enable ? (~bin_prev & bin_sync) : remove_subcommand;
  // crossing onto a step point in the direction of current flow
  assign step_evt  = step_on && (charge_percent != pct_prev) && is_step_point(charge_percent, charge_step_size) &&
                     ((charging && charge_percent > pct_prev) || (discharging && charge_percent < pct_prev));
  assign state_evt = step_on && ((charging && !chg_prev) || (discharging && !dis_prev));
  assign rem_pulse = pin_detect_enable && (~bin_prev & bin_sync);
  assign new_evts  = {2'b00, step_evt} + {2'b00, state_evt} + {2'b00, rem_pulse};
  assign start_pulse = !pulse_on && (pend_cnt != 4'h0);
  assign pend_sum    = {1'b0, pend_cnt} + {2'b00, new_evts} - {4'h0, start_pulse};

  // two-stage synchroniser then edge history on the detect pin
  always @(posedge ref_clk)
  begin
    if (srst)
    begin
      bin_meta <= 1'b1;
      bin_sync <= 1'b1;
      bin_prev <= 1'b1;
    end
    else
    begin
      bin_meta <= battery_present_input;
      bin_sync <= bin_meta;
      bin_prev <= bin_sync;
    end
  end

  // charge threshold flags with hysteresis on the final flag
  always @(posedge ref_clk)
  begin
    if (srst)
    begin
      charge_initial_flag <= 1'b0;
      charge_final_flag   <= 1'b0;
    end
    else
    begin
      if (charge_percent < first_set_threshold)
        charge_initial_flag <= 1'b1;
      else if (charge_percent > first_set_threshold)
        charge_initial_flag <= 1'b0;
      if (charge_percent < final_set_threshold)
        charge_final_flag <= 1'b1;
      else if (charge_final_flag && charge_percent > final_clear_threshold)
        charge_final_flag <= 1'b0;
    end
  end

  // event history and pulse queue; a full queue saturates
  always @(posedge ref_clk)
  begin
    if (srst)
    begin
      pct_prev  <= 7'h00;
      chg_prev  <= 1'b0;
      dis_prev  <= 1'b0;
      pend_cnt  <= 4'h0;
      pulse_cnt <= 32'h0;
      pulse_on  <= 1'b0;
    end
    else
    begin
      pct_prev <= charge_percent;
      chg_prev <= charging;
      dis_prev <= discharging;
      // arrivals during a pulse wait in the queue
      if (pend_sum > 5'h0F)
        pend_cnt <= 4'hF;
      else
        pend_cnt <= pend_sum[3:0];
      if (start_pulse)
      begin
        pulse_on  <= 1'b1;
        pulse_cnt <= 32'h0;
      end
      else if (pulse_on)
      begin
        if (pulse_cnt == PULSE_CYCLES - 1)
          pulse_on <= 1'b0;
        else
          pulse_cnt <= pulse_cnt + 32'h1;
      end
    end
  end

  // pin function select and polarity
  always @*
  begin
    if (low_battery_output_select)
      next_pin = charge_initial_flag;
    else
      next_pin = pulse_on;
    next_pin = next_pin ^ output_polarity_select;
  end

  // output pin register
  always @(posedge ref_clk)
  begin
    if (srst)
      general_output_pin <= 1'b0;
    else
      general_output_pin <= next_pin;
  end

  // operating mode: init waits for insertion, prep runs init, then normal
  always @(posedge ref_clk)
  begin
    if (srst)
    begin
      battery_inserted <= 1'b0;
      gauge_mode       <= `SAB_MODE_INIT;
      gauging_active   <= 1'b0;
      init_cnt         <= 32'h0;
      wake_cnt         <= 32'h0;
      core_awake       <= 1'b0;
    end
    else
    begin
      // insertion wins over a same-cycle removal
      if (ins_evt)
        battery_inserted <= 1'b1;
      else if (rem_evt)
        battery_inserted <= 1'b0;
      case (gauge_mode)
        `SAB_MODE_INIT:
        begin
          if (ins_evt)
          begin
            gauge_mode <= `SAB_MODE_PREP;
            init_cnt   <= 32'h0;
          end
        end
        `SAB_MODE_PREP:
        begin
          if (rem_evt && !ins_evt)
            gauge_mode <= `SAB_MODE_INIT;
          else if (init_cnt == INIT_CYCLES - 1)
            gauge_mode <= `SAB_MODE_NORMAL;
          else
            init_cnt <= init_cnt + 32'h1;
        end
        `SAB_MODE_NORMAL:
        begin
          if (rem_evt && !ins_evt)
            gauge_mode <= `SAB_MODE_INIT;
        end
        default:
          gauge_mode <= `SAB_MODE_INIT;
      endcase
      gauging_active <= (gauge_mode == `SAB_MODE_NORMAL) && !(rem_evt && !ins_evt);
      // halted core wakes for a host command then halts again
      if (gauge_mode != `SAB_MODE_INIT)
      begin
        core_awake <= 1'b1;
        wake_cnt   <= 32'h0;
      end
      else if (host_command)
      begin
        core_awake <= 1'b1;
        wake_cnt   <= 32'h0;
      end
      else if (core_awake)
      begin
        if (wake_cnt >= CMD_CYCLES - 1)
          core_awake <= 1'b0;
        else
          wake_cnt <= wake_cnt + 32'h1;
      end
    end
  end

endmodule // sab_alert_detect
